// ===== rtl/tnc_pkg.sv
// Constants, command codes and states of the trap and source-routing block
package tnc_pkg;
    // Register placement and reset values
    localparam logic [19:0] TNC_ROUTE_ADDR   = 20'hFFA9;
    localparam logic [7:0]  TNC_ROUTE_RESET  = 8'h00;
    localparam logic [7:0]  TNC_STATUS_RESET = 8'h00;
    localparam int          TNC_ROUTE_BITS   = 2;
    // Field positions
    localparam int TNC_PIN_BIT  = 0;
    localparam int TNC_WDT_BIT  = 1;
    localparam int TNC_IE_BIT   = 3;
    localparam int TNC_RSVD_BIT = 1;
    // Vector table addresses; the operand error slot value is arbitrary
    localparam logic [15:0] TNC_BRK_VEC   = 16'h003E;
    localparam logic [15:0] TNC_OPERR_VEC = 16'h003C;
    localparam logic [3:0]  TNC_BASE_HIGH = 4'h0;
    localparam logic [11:0] TNC_PAD12     = 12'h000;

    // Commands issued by the instruction sequencer
    typedef enum logic [3:0] {
        TNC_CMD_PUSH, TNC_CMD_POP, TNC_CMD_INTERRUPT_RETURN_INSN, TNC_CMD_BREAK_RETURN_INSN,
        TNC_CMD_BANK_IRQ_RETURN_INSN, TNC_CMD_BANK_BREAK_RETURN_INSN, TNC_CMD_BRK, TNC_CMD_BANK_BREAK_TRAP_INSN,
        TNC_CMD_VACK, TNC_CMD_CSACK, TNC_CMD_CHECK, TNC_CMD_OPERR
    } tnc_cmd_t;

    // Trap entry sequencer states
    typedef enum logic [2:0] {
        TNC_ST_IDLE, TNC_ST_PUSH_PSW, TNC_ST_PUSH_PC, TNC_ST_VEC,
        TNC_ST_BANK, TNC_ST_BRANCH
    } tnc_state_t;
endpackage

// ===== rtl/tnc_route_reg.sv
// Once-settable source-routing register with bit and byte writes
`timescale 1ns/1ps
module tnc_route_reg
    import tnc_pkg::*;
#(
    parameter int WIDTH = TNC_ROUTE_BITS
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             wr_byte_i,
    input  wire logic             wr_bit_i,
    input  wire logic [2:0]       bit_sel_i,
    input  wire logic [7:0]       wdata_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] set_ff;

    // Each bit may only go from 0 to 1; a 1 sticks until reset
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            wire logic hit = wr_byte_i | (wr_bit_i & (bit_sel_i == 3'(gi)));
            wire logic nxt_set = set_ff[gi] | (hit & wdata_i[gi]);
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    set_ff[gi] <= TNC_ROUTE_RESET[gi];
                end else begin
                    set_ff[gi] <= nxt_set;
                end
            end
        end
    endgenerate

    assign q_o = set_ff;
endmodule

// ===== rtl/tnc_exc_ctrl.sv
// Trap entry sequencing, status byte and interrupt source routing
`timescale 1ns/1ps
// Summary of operation
// - Routing bits reset zero, settable once only
// - Watchdog routed non-maskable or masked maskable
// - Shared pin acts as request two or non-maskable
// - Routing register takes bit and byte writes
// - Status byte resets zero; enable flag gates acceptance
// - Vectored ack and break push status, clear enable
// - Push stores status; returns and pop reload it
// - Bank switch saves status in bank, clears enable
// - Software traps always taken, masks ignored
// - Break pushes status, counter, loads fixed vector
// - Bank break selects bank, saves context, branches
// - Bank break return sets next base-area start
// - Inverted third operand byte must equal fourth
// - Operand error pushes status and faulting address
// - Priority bit orders pin and watchdog requests
module tnc_exc_ctrl
    import tnc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic [19:0] mem_addr_i,
    input  wire logic        mem_wr_byte_i,
    input  wire logic        mem_wr_bit_i,
    input  wire logic        mem_rd_i,
    input  wire logic [2:0]  mem_bit_sel_i,
    input  wire logic [7:0]  mem_wdata_i,
    output logic      [7:0]  mem_rdata_o,
    input  wire logic        psw_wr_byte_i,
    input  wire logic        psw_wr_bit_i,
    input  wire logic [2:0]  psw_bit_sel_i,
    input  wire logic [7:0]  psw_wdata_i,
    input  wire logic        ei_i,
    input  wire logic        di_i,
    output logic      [7:0]  status_byte_low_o,
    output logic             irq_enable_flag_o,
    input  wire logic        cmd_valid_i,
    input  wire tnc_cmd_t    cmd_i,
    input  wire logic [7:0]  cmd_data_i,
    input  wire logic [19:0] cmd_pc_i,
    input  wire logic [2:0]  cmd_bank_i,
    input  wire logic [7:0]  opnd3_i,
    input  wire logic [7:0]  opnd4_i,
    input  wire logic [15:0] vec_addr_i,
    input  wire logic [19:0] bank_vec_i,
    input  wire logic [15:0] vec_data_i,
    output logic             busy_o,
    output logic             stk_push_o,
    output logic      [19:0] stk_data_o,
    output logic             vec_rd_o,
    output logic      [15:0] vec_rd_addr_o,
    output logic             bank_wr_o,
    output logic      [2:0]  bank_sel_o,
    output logic      [7:0]  bank_psw_o,
    output logic      [19:0] bank_pc_o,
    output logic             bank_vec_wr_o,
    output logic             pc_load_o,
    output logic      [19:0] pc_new_o,
    output logic             op_err_o,
    input  wire logic        wdt_req_i,
    input  wire logic        wdt_mask_i,
    input  wire logic        pin_req_i,
    input  wire logic        pin_mask_i,
    input  wire logic        watchdog_priority_bit_i,
    output logic             wdt_nmi_o,
    output logic             wdt_maskable_o,
    output logic             pin_nmi_o,
    output logic             ext_request_two_o,
    output logic             nmi_take_wdt_o,
    output logic             nmi_take_pin_o,
    output logic             standby_rel_nmi_o,
    output logic             standby_rel_mi_o,
    output logic             irq_accept_o
);
    tnc_state_t  state_ff, nxt_state;
    tnc_cmd_t    kind_ff, nxt_kind;
    logic [7:0]  status_ff, nxt_status;
    logic [19:0] stk_data_ff, nxt_stk_data;
    logic [19:0] pc_save_ff, nxt_pc_save;
    logic [19:0] pc_new_ff, nxt_pc_new;
    logic [15:0] vec_addr_ff, nxt_vec_addr;
    logic [2:0]  bank_ff, nxt_bank;
    logic [7:0]  rdata_ff, nxt_rdata;
    logic        op_err_ff, nxt_op_err;
    logic [TNC_ROUTE_BITS-1:0] route_q;

    // Command decode
    wire logic take        = cmd_valid_i & (state_ff == TNC_ST_IDLE);
    wire logic opnd_bad    = (~opnd3_i) != opnd4_i;
    wire logic is_check    = take & (cmd_i == TNC_CMD_CHECK);
    wire logic is_brk      = cmd_i == TNC_CMD_BRK;
    wire logic is_operr    = (cmd_i == TNC_CMD_OPERR) | ((cmd_i == TNC_CMD_CHECK) & opnd_bad);
    wire logic is_stk_trap = is_brk | is_operr | (cmd_i == TNC_CMD_VACK);
    wire logic is_bank     = (cmd_i == TNC_CMD_BANK_BREAK_TRAP_INSN) | (cmd_i == TNC_CMD_CSACK);
    wire logic is_restore  = (cmd_i == TNC_CMD_POP) | (cmd_i == TNC_CMD_INTERRUPT_RETURN_INSN) |
                             (cmd_i == TNC_CMD_BREAK_RETURN_INSN) | (cmd_i == TNC_CMD_BANK_IRQ_RETURN_INSN) |
                             (cmd_i == TNC_CMD_BANK_BREAK_RETURN_INSN);
    wire logic ie_clear    = ((state_ff == TNC_ST_PUSH_PSW) & (kind_ff != TNC_CMD_PUSH)) |
                             (state_ff == TNC_ST_BANK);
    wire logic route_hit   = mem_addr_i == TNC_ROUTE_ADDR;

    // Routing register, written by bit or byte memory operations
    tnc_route_reg #(
        .WIDTH(TNC_ROUTE_BITS)
    ) u_route (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .wr_byte_i(mem_wr_byte_i & route_hit),
        .wr_bit_i (mem_wr_bit_i & route_hit),
        .bit_sel_i(mem_bit_sel_i),
        .wdata_i  (mem_wdata_i),
        .q_o      (route_q)
    );

    // Source routing and non-maskable ordering
    assign wdt_nmi_o         = wdt_req_i & ~route_q[TNC_WDT_BIT];
    assign wdt_maskable_o    = wdt_req_i & route_q[TNC_WDT_BIT] & ~wdt_mask_i;
    assign pin_nmi_o         = pin_req_i & route_q[TNC_PIN_BIT];
    assign ext_request_two_o = pin_req_i & ~route_q[TNC_PIN_BIT] & ~pin_mask_i;
    assign standby_rel_nmi_o = pin_nmi_o;
    assign standby_rel_mi_o  = ext_request_two_o;
    assign nmi_take_wdt_o    = wdt_nmi_o & (watchdog_priority_bit_i | ~pin_nmi_o);
    assign nmi_take_pin_o    = pin_nmi_o & (~watchdog_priority_bit_i | ~wdt_nmi_o);

    // Status byte update: software writes, restores, trap clear, then reserved bit forced zero last
    always_comb begin
        nxt_status = status_ff;
        if (psw_wr_byte_i) begin
            nxt_status = psw_wdata_i;
        end else if (psw_wr_bit_i) begin
            nxt_status[psw_bit_sel_i] = psw_wdata_i[0];
        end
        if (ei_i) begin
            nxt_status[TNC_IE_BIT] = 1'b1;
        end
        if (di_i) begin
            nxt_status[TNC_IE_BIT] = 1'b0;
        end
        if (take & is_restore) begin
            nxt_status = cmd_data_i;
        end
        if (ie_clear) begin
            nxt_status[TNC_IE_BIT] = 1'b0;
        end
        nxt_status[TNC_RSVD_BIT] = 1'b0;
    end

    // Trap entry sequencer; runs to the branch without accepting commands
    always_comb begin
        nxt_state    = state_ff;
        nxt_kind     = kind_ff;
        nxt_stk_data = stk_data_ff;
        nxt_pc_save  = pc_save_ff;
        nxt_pc_new   = pc_new_ff;
        nxt_vec_addr = vec_addr_ff;
        nxt_bank     = bank_ff;
        unique case (state_ff)
            TNC_ST_IDLE: begin
                if (take) begin
                    nxt_kind     = is_operr ? TNC_CMD_OPERR : cmd_i;
                    nxt_pc_save  = cmd_pc_i;
                    nxt_bank     = cmd_bank_i;
                    nxt_stk_data = {TNC_PAD12, status_ff};
                    nxt_vec_addr = is_brk ? TNC_BRK_VEC :
                                   (is_operr ? TNC_OPERR_VEC : vec_addr_i);
                    nxt_pc_new   = bank_vec_i;
                    if (is_stk_trap | (cmd_i == TNC_CMD_PUSH)) begin
                        nxt_state = TNC_ST_PUSH_PSW;
                    end else if (is_bank) begin
                        nxt_state = TNC_ST_BANK;
                    end
                end
            end
            TNC_ST_PUSH_PSW: begin
                nxt_stk_data = pc_save_ff;
                nxt_state    = (kind_ff == TNC_CMD_PUSH) ? TNC_ST_IDLE : TNC_ST_PUSH_PC;
            end
            TNC_ST_PUSH_PC: begin
                nxt_state = TNC_ST_VEC;
            end
            TNC_ST_VEC: begin
                nxt_pc_new = {TNC_BASE_HIGH, vec_data_i};
                nxt_state  = TNC_ST_BRANCH;
            end
            TNC_ST_BANK: begin
                nxt_state = TNC_ST_BRANCH;
            end
            TNC_ST_BRANCH: begin
                nxt_state = TNC_ST_IDLE;
            end
        endcase
    end

    // Registered read data and operand error pulse
    assign nxt_rdata  = (mem_rd_i & route_hit) ? {6'h00, route_q} : 8'h00;
    assign nxt_op_err = is_check & opnd_bad;

    // State and data registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff    <= TNC_ST_IDLE;
            kind_ff     <= TNC_CMD_PUSH;
            status_ff   <= TNC_STATUS_RESET;
            stk_data_ff <= 20'h00000;
            pc_save_ff  <= 20'h00000;
            pc_new_ff   <= 20'h00000;
            vec_addr_ff <= 16'h0000;
            bank_ff     <= 3'h0;
            rdata_ff    <= 8'h00;
            op_err_ff   <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            kind_ff     <= nxt_kind;
            status_ff   <= nxt_status;
            stk_data_ff <= nxt_stk_data;
            pc_save_ff  <= nxt_pc_save;
            pc_new_ff   <= nxt_pc_new;
            vec_addr_ff <= nxt_vec_addr;
            bank_ff     <= nxt_bank;
            rdata_ff    <= nxt_rdata;
            op_err_ff   <= nxt_op_err;
        end
    end

    // Outputs
    assign mem_rdata_o       = rdata_ff;
    assign status_byte_low_o = status_ff;
    assign irq_enable_flag_o = status_ff[TNC_IE_BIT];
    assign irq_accept_o      = status_ff[TNC_IE_BIT] & (wdt_maskable_o | ext_request_two_o);
    assign busy_o            = state_ff != TNC_ST_IDLE;
    assign stk_push_o        = (state_ff == TNC_ST_PUSH_PSW) | (state_ff == TNC_ST_PUSH_PC);
    assign stk_data_o        = stk_data_ff;
    assign vec_rd_o          = state_ff == TNC_ST_PUSH_PC;
    assign vec_rd_addr_o     = vec_addr_ff;
    assign bank_wr_o         = state_ff == TNC_ST_BANK;
    assign bank_sel_o        = bank_ff;
    assign bank_psw_o        = stk_data_ff[7:0];
    assign bank_pc_o         = pc_save_ff;
    assign bank_vec_wr_o     = take & (cmd_i == TNC_CMD_BANK_BREAK_RETURN_INSN);
    assign pc_load_o         = state_ff == TNC_ST_BRANCH;
    assign pc_new_o          = pc_new_ff;
    assign op_err_o          = op_err_ff;

    // Checks
    sequence s_stack_entry;
        stk_push_o ##1 (stk_push_o && vec_rd_o) ##1 (busy_o && !pc_load_o) ##1 pc_load_o;
    endsequence

    AST_ROUTE_ONCE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        1'b1 |=> ((route_q & $past(route_q)) == $past(route_q)))
        else $error("routing bit cleared after set");
    AST_WDT_ROUTE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wdt_req_i && !route_q[TNC_WDT_BIT]) |-> (wdt_nmi_o && !wdt_maskable_o))
        else $error("watchdog not routed non-maskable");
    AST_PIN_ROUTE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (pin_req_i && !route_q[TNC_PIN_BIT] && !pin_mask_i) |-> (ext_request_two_o && !pin_nmi_o))
        else $error("pin not routed as request two");
    AST_IE_GATE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        irq_accept_o == (irq_enable_flag_o && (wdt_maskable_o || ext_request_two_o)))
        else $error("acceptance not gated by enable flag");
    AST_BRK_ENTRY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (take && is_brk) |=> s_stack_entry ##0 (pc_new_o[19:16] == TNC_BASE_HIGH) ##0
        (vec_rd_addr_o == TNC_BRK_VEC))
        else $error("break entry sequence wrong");
    AST_IE_CLEAR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == TNC_ST_PUSH_PSW && kind_ff != TNC_CMD_PUSH) |=> !status_ff[TNC_IE_BIT])
        else $error("enable flag not cleared on entry");
    AST_BANK_ENTRY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (take && is_bank) |=> (bank_wr_o && bank_sel_o == $past(cmd_bank_i)) ##1
        (pc_load_o && pc_new_o == $past(bank_vec_i, 2)))
        else $error("bank switch entry wrong");
    AST_OPERR_SAVE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        is_check && opnd_bad |=> (stk_data_o[7:0] == $past(status_ff)) ##1
        (stk_data_o == $past(cmd_pc_i, 2)))
        else $error("operand error context wrong");
    AST_RESTORE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (take && is_restore && !ie_clear) |=>
        (status_ff[7:4] == $past(cmd_data_i[7:4])))
        else $error("status not restored");
    AST_ATOMIC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (take && is_stk_trap) |=> busy_o[*4] ##1 !busy_o)
        else $error("trap entry not atomic");
endmodule

// ===== tb/tnc_vec_model.sv
// Vector table model facing the trap sequencer
`timescale 1ns/1ps
module tnc_vec_model
    import tnc_pkg::*;
#(
    parameter logic [15:0] SALT = 16'h5A3C
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        vec_rd_i,
    input  wire logic [15:0] vec_addr_i,
    output logic      [15:0] vec_data_o
);
    // Word valid only in the cycle after a strobe; toggles otherwise so stale data shows
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vec_data_o <= 16'hA5A5;
        end else if (vec_rd_i) begin
            vec_data_o <= vec_addr_i ^ SALT;
        end else begin
            vec_data_o <= ~vec_data_o;
        end
    end
endmodule

// ===== tb/test_trap_and_nmi_source_control.sv
// Self-checking bench of trap sequencing, status byte and source routing
`timescale 1ns/1ps
module test_trap_and_nmi_source_control
    import tnc_pkg::*;
;
    localparam logic [15:0] VSALT = 16'h5A3C;
    logic        mclk_i, rst_n_i, mem_wr_byte_i, mem_wr_bit_i, mem_rd_i, psw_wr_byte_i;
    logic        psw_wr_bit_i, ei_i, di_i, cmd_valid_i, wdt_req_i, wdt_mask_i, pin_req_i;
    logic        pin_mask_i, watchdog_priority_bit_i, irq_enable_flag_o, busy_o, stk_push_o;
    logic        vec_rd_o, bank_wr_o, bank_vec_wr_o, pc_load_o, op_err_o, wdt_nmi_o, pin_nmi_o;
    logic        wdt_maskable_o, ext_request_two_o, nmi_take_wdt_o, nmi_take_pin_o, bvw, bsy;
    logic        standby_rel_nmi_o, standby_rel_mi_o, irq_accept_o;
    logic [2:0]  mem_bit_sel_i, psw_bit_sel_i, cmd_bank_i, bank_sel_o, bs;
    logic [7:0]  mem_wdata_i, psw_wdata_i, cmd_data_i, opnd3_i, opnd4_i, mem_rdata_o, bp, st;
    logic [7:0]  status_byte_low_o, bank_psw_o;
    logic [15:0] vec_addr_i, vec_data_i, vec_rd_addr_o, va;
    logic [19:0] mem_addr_i, cmd_pc_i, bank_vec_i, stk_data_o, bank_pc_o, pc_new_o;
    logic [19:0] ps0, ps1, pn, bpc, pc;
    logic [31:0] seed;
    tnc_cmd_t    cmd_i;
    int          fail_count, n_compared, np, kl, ke, kb;

    tnc_exc_ctrl u_dut (.*);
    tnc_vec_model #(.SALT(VSALT)) u_vec (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .vec_rd_i(vec_rd_o), .vec_addr_i(vec_rd_addr_o), .vec_data_o(vec_data_i));

    // Clock of 10 ns
    initial begin
        mclk_i = 1'h0;
        forever #5 mclk_i = ~mclk_i;
    end

    // Xorshift source with fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Compare a value and count it
    task automatic chk_val(input string nm, input logic [19:0] e, input logic [19:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Summary and verdict
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Memory byte or bit write, one cycle strobe
    task automatic mwr(input logic bw, input logic [19:0] a, input logic [7:0] d,
                       input logic [2:0] s);
        @(posedge mclk_i);
        mem_addr_i <= a;
        mem_wdata_i <= d;
        mem_bit_sel_i <= s;
        mem_wr_byte_i <= !bw;
        mem_wr_bit_i <= bw;
        @(posedge mclk_i);
        mem_wr_byte_i <= 1'h0;
        mem_wr_bit_i <= 1'h0;
    endtask

    // Memory read; data registered one cycle later
    task automatic mrd(input logic [19:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        mem_addr_i <= a;
        mem_rd_i <= 1'h1;
        @(posedge mclk_i);
        mem_rd_i <= 1'h0;
        @(negedge mclk_i);
        chk_val("read data", e, mem_rdata_o);
    endtask

    // Status byte write, or enable and disable pulses
    task automatic pwr(input logic bw, input logic by, input logic e, input logic d,
                       input logic [7:0] v, input logic [2:0] s);
        @(posedge mclk_i);
        {psw_wr_bit_i, psw_wr_byte_i, ei_i, di_i} <= {bw, by, e, d};
        psw_wdata_i <= v;
        psw_bit_sel_i <= s;
        @(posedge mclk_i);
        {psw_wr_bit_i, psw_wr_byte_i, ei_i, di_i} <= 4'h0;
        @(negedge mclk_i);
    endtask

    // Random request levels against the routing bits
    task automatic rchk(input logic [1:0] r, input logic ie);
        logic wn, wm, pq, e2;
        repeat (12) begin
            @(posedge mclk_i);
            {wdt_req_i, wdt_mask_i, pin_req_i, pin_mask_i, watchdog_priority_bit_i} <= 5'(rnd());
            @(negedge mclk_i);
            wn = wdt_req_i & ~r[1];
            wm = wdt_req_i & r[1] & ~wdt_mask_i;
            pq = pin_req_i & r[0];
            e2 = pin_req_i & ~r[0] & ~pin_mask_i;
            chk_val("wdt nmi", wn, wdt_nmi_o);
            chk_val("wdt maskable", wm, wdt_maskable_o);
            chk_val("pin nmi", pq, pin_nmi_o);
            chk_val("ext two", e2, ext_request_two_o);
            chk_val("standby nmi", pq, standby_rel_nmi_o);
            chk_val("standby mi", e2, standby_rel_mi_o);
            chk_val("take wdt", wn & (~pq | watchdog_priority_bit_i), nmi_take_wdt_o);
            chk_val("take pin", pq & (~wn | ~watchdog_priority_bit_i), nmi_take_pin_o);
            chk_val("accept", ie & (wm | e2), irq_accept_o);
        end
        $display("test routing %b finished", r);
    endtask

    // Issue one command and record the sequence; poke keeps pushing while busy
    task automatic run_cmd(input tnc_cmd_t c, input logic poke);
        st = status_byte_low_o;
        pc = 20'(rnd());
        {np, kl, ke, kb, bvw, bsy} = {32'd0, -32'sd1, -32'sd1, -32'sd1, 2'h0};
        @(posedge mclk_i);
        cmd_valid_i <= 1'h1;
        cmd_i <= c;
        cmd_pc_i <= pc;
        for (int k = 0; k < 8; k++) begin
            @(negedge mclk_i);
            if (stk_push_o === 1'h1 && np == 1) ps1 = stk_data_o;
            if (stk_push_o === 1'h1 && np == 0) ps0 = stk_data_o;
            if (stk_push_o === 1'h1) np++;
            if (vec_rd_o === 1'h1) va = vec_rd_addr_o;
            if (pc_load_o === 1'h1) {kl, pn} = {k, pc_new_o};
            if (op_err_o === 1'h1) ke = k;
            if (bank_wr_o === 1'h1) {kb, bs, bp, bpc} = {k, bank_sel_o, bank_psw_o, bank_pc_o};
            if (bank_vec_wr_o === 1'h1) bvw = 1'h1;
            if (k == 1) bsy = busy_o;
            @(posedge mclk_i);
            if (k == 0 && poke) cmd_i <= TNC_CMD_PUSH;
            else if (k == 0 || k == 3) cmd_valid_i <= 1'h0;
        end
    endtask

    // Stack-based trap entry: status, counter, vector
    task automatic trap_chk(input logic [15:0] slot);
        chk_val("push count", 2, np);
        chk_val("push status", {12'h000, st}, ps0);
        chk_val("push pc", pc, ps1);
        chk_val("vector slot", slot, va);
        chk_val("load cycle", 4, kl);
        chk_val("new pc", {TNC_BASE_HIGH, slot ^ VSALT}, pn);
        chk_val("busy", 1, bsy);
        chk_val("enable cleared", 0, irq_enable_flag_o);
    endtask

    initial begin
        {mem_wr_byte_i, mem_wr_bit_i, mem_rd_i, psw_wr_byte_i, psw_wr_bit_i} = 5'h0;
        {ei_i, di_i, cmd_valid_i, wdt_req_i, wdt_mask_i, pin_req_i, pin_mask_i} = 7'h0;
        {watchdog_priority_bit_i, mem_bit_sel_i, psw_bit_sel_i, cmd_bank_i} = 10'h0;
        {mem_wdata_i, psw_wdata_i, cmd_data_i, opnd3_i, opnd4_i} = 40'h0;
        {vec_addr_i, mem_addr_i, cmd_pc_i, bank_vec_i} = 76'h0;
        {seed, fail_count, n_compared, rst_n_i} = {32'hB7A6, 64'd0, 1'h0};
        cmd_i = TNC_CMD_PUSH;
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        @(negedge mclk_i);
        chk_val("status reset", TNC_STATUS_RESET, status_byte_low_o);
        mrd(TNC_ROUTE_ADDR, TNC_ROUTE_RESET);
        rchk(2'h0, 1'h0);
        mwr(1'h0, TNC_ROUTE_ADDR, 8'hFE, 3'h0);
        mrd(TNC_ROUTE_ADDR, 8'h02);
        mwr(1'h0, TNC_ROUTE_ADDR, 8'h00, 3'h0);
        mrd(TNC_ROUTE_ADDR, 8'h02);
        pwr(1'h0, 1'h0, 1'h1, 1'h0, 8'h00, 3'h0);
        rchk(2'h2, 1'h1);
        mwr(1'h1, TNC_ROUTE_ADDR, 8'h01, 3'h0);
        mrd(TNC_ROUTE_ADDR, 8'h03);
        mrd(20'hFFA8, 8'h00);
        rchk(2'h3, 1'h1);
        // Status byte by byte, bit and dedicated writes
        repeat (4) begin
            st = 8'(rnd());
            pwr(1'h0, 1'h1, 1'h0, 1'h0, st, 3'h0);
            chk_val("status byte", st & 8'hFD, status_byte_low_o);
        end
        pwr(1'h0, 1'h0, 1'h0, 1'h1, 8'h00, 3'h0);
        chk_val("disable", 0, irq_enable_flag_o);
        pwr(1'h1, 1'h0, 1'h0, 1'h0, 8'h01, 3'h3);
        chk_val("bit enable", 1, irq_enable_flag_o);
        run_cmd(TNC_CMD_PUSH, 1'h0);
        chk_val("push count", 1, np);
        chk_val("push status", {12'h000, st}, ps0);
        // Break and vectored acknowledge, break with a push refused while busy
        for (int j = 0; j < 2; j++) begin
            pwr(1'h0, 1'h0, 1'h1, 1'h0, 8'h00, 3'h0);
            @(posedge mclk_i);
            vec_addr_i <= {8'h00, 7'(rnd()), 1'h0};
            run_cmd(j == 0 ? TNC_CMD_BRK : TNC_CMD_VACK, j == 0);
            trap_chk(j == 0 ? TNC_BRK_VEC : vec_addr_i);
        end
        // Status reloads; break exits by break return, bank trap by bank return
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk_i);
            cmd_data_i <= 8'(rnd());
            run_cmd(i == 0 ? TNC_CMD_POP : i == 1 ? TNC_CMD_INTERRUPT_RETURN_INSN : i == 2 ? TNC_CMD_BREAK_RETURN_INSN
                    : i == 3 ? TNC_CMD_BANK_IRQ_RETURN_INSN : TNC_CMD_BANK_BREAK_RETURN_INSN, 1'h0);
            chk_val("restore", cmd_data_i & 8'hFD, status_byte_low_o);
            chk_val("next start write", i == 4, bvw);
        end
        // Bank trap and context switch acknowledge
        for (int j = 0; j < 2; j++) begin
            pwr(1'h0, 1'h0, 1'h1, 1'h0, 8'h00, 3'h0);
            @(posedge mclk_i);
            {cmd_bank_i, bank_vec_i} <= 23'(rnd());
            run_cmd(j == 0 ? TNC_CMD_BANK_BREAK_TRAP_INSN : TNC_CMD_CSACK, 1'h0);
            chk_val("bank select", cmd_bank_i, bs);
            chk_val("bank status", st, bp);
            chk_val("bank pc", pc, bpc);
            chk_val("bank cycle", 1, kb);
            chk_val("bank branch", {bank_vec_i}, pn);
            chk_val("bank load cycle", 2, kl);
            chk_val("bank enable", 0, irq_enable_flag_o);
        end
        // Operand check passing, then failing by one bit
        for (int j = 0; j < 2; j++) begin
            pwr(1'h0, 1'h0, 1'h1, 1'h0, 8'h00, 3'h0);
            @(posedge mclk_i);
            opnd3_i <= 8'(rnd());
            @(posedge mclk_i);
            opnd4_i <= ~opnd3_i ^ 8'(j);
            run_cmd(TNC_CMD_CHECK, 1'h0);
            chk_val("error pulse", j == 0 ? -1 : 1, 20'(ke));
            if (j == 0) chk_val("no branch", 20'hFFFFF, 20'(kl));
            else trap_chk(TNC_OPERR_VEC);
        end
        // Handler discards the stacked start address and reloads status by pop
        // Direct operand error entry from the sequencer
        pwr(1'h0, 1'h0, 1'h1, 1'h0, 8'h00, 3'h0);
        run_cmd(TNC_CMD_OPERR, 1'h0);
        trap_chk(TNC_OPERR_VEC);
        cmd_data_i <= 8'h00;
        run_cmd(TNC_CMD_POP, 1'h0);
        chk_val("pop status", 0, status_byte_low_o);
        $display("test commands finished");
        test_done();
    end

    // Cut a hang short
    initial begin
        #300us;
        fail_count++;
        test_done();
    end
endmodule
